// ---- core/eight_bit_timer_control.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "timer_map.svh"

module eight_bit_timer_control
  import timer_pkg::*;
(
  input  wire logic        hclk,       // system clock, 10 MHz
  input  wire logic        hresetn,    // async reset, low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write when high
  input  wire logic [2:0]  hsize,      // transfer size
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready in
  output logic [31:0]      hrdata,     // read data
  output logic             hreadyout,  // slave ready
  output logic             hresp,      // always okay
  input  wire logic [1:0]  ext_clk,    // external count pins
  input  wire logic [1:0]  ext_rst,    // external clear pins
  output logic             irq         // level interrupt
);

  // software registers
  timer_ctrl_t ctrl0;        // control channel 0
  timer_ctrl_t ctrl1;        // control channel 1
  logic [7:0]  tc_a0;        // constant a channel 0
  logic [7:0]  tc_b0;        // constant b channel 0
  logic [7:0]  tc_a1;        // constant a channel 1
  logic [7:0]  tc_b1;        // constant b channel 1
  logic [5:0]  status;       // sticky event bits
  logic [5:0]  mask;         // interrupt mask, 1 passes
  // bus slave state
  bus_state_t  bus_state;    // idle or read wait
  logic        wr_pend;      // write data phase due
  logic [7:0]  wr_addr;      // latched write address
  logic [7:0]  rd_addr;      // latched read address
  logic        addr_take;    // valid address phase
  logic        wr_now;       // write lands this cycle
  // timing helpers
  logic [`PRESC_WIDTH-1:0] presc;       // free prescaler
  logic [2:0]              presc_tick;  // divided ticks
  logic [3:0]              pin_s1;      // first sync stage
  logic [3:0]              pin_s2;      // second sync stage
  logic [3:0]              pin_s3;      // edge history
  pin_evt_t                pin0;        // channel 0 pin events
  pin_evt_t                pin1;        // channel 1 pin events
  // channel results
  logic [7:0]  cnt0;         // counter channel 0
  logic [7:0]  cnt1;         // counter channel 1
  timer_evt_t  evt0;         // events channel 0
  timer_evt_t  evt1;         // events channel 1
  logic        casc0;        // channel 1 overflow, delayed
  logic        casc1;        // channel 0 match a, delayed
  logic        casc_both;    // both in cascade mode
  logic [5:0]  evt_all;      // all events, status layout
  logic [5:0]  enables;      // enable bits, status layout
  logic [5:0]  w1c;          // bits software clears
  logic [5:0]  next_status;  // status after this cycle
  // tick when the low prescaler bits roll over
  function automatic logic div_tick(
    input logic [`PRESC_WIDTH-1:0] cnt,
    input int unsigned             div
  );
    logic [`PRESC_WIDTH-1:0] m;
    m = `PRESC_WIDTH'(div - 1);
    return (cnt & m) == m;
  endfunction : div_tick

  // read mux over the register map
  function automatic logic [31:0] read_reg(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `REG_CTRL_CH0:   d[7:0] = ctrl0;
      `REG_CTRL_CH1:   d[7:0] = ctrl1;
      `REG_COUNT_CH0:  d[7:0] = cnt0;
      `REG_COUNT_CH1:  d[7:0] = cnt1;
      `REG_TCONST_A0:  d[7:0] = tc_a0;
      `REG_TCONST_B0:  d[7:0] = tc_b0;
      `REG_TCONST_A1:  d[7:0] = tc_a1;
      `REG_TCONST_B1:  d[7:0] = tc_b1;
      `REG_IRQ_STATUS: d[5:0] = status;
      `REG_IRQ_MASK:   d[5:0] = mask;
      default:         d = 32'h0000_0000;  // unmapped reads zero
    endcase
    return d;
  endfunction : read_reg

  // bus decode
  assign addr_take = hsel & hready & htrans[1];
  assign wr_now    = wr_pend;

  // bus slave: writes zero-wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state <= BUS_IDLE;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;  // response is always okay
      hrdata    <= 32'h0000_0000;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      rd_addr   <= 8'h00;
    end
    else
    begin
      case (bus_state)
        BUS_IDLE:
        begin
          wr_pend <= addr_take & hwrite;
          if (addr_take)
          begin
            wr_addr <= haddr[7:0];
            rd_addr <= haddr[7:0];
          end
          // a read waits so that a write just before lands first
          if (addr_take & ~hwrite)
          begin
            bus_state <= BUS_READ;
            hreadyout <= 1'b0;
          end
        end
        BUS_READ:
        begin
          wr_pend   <= 1'b0;
          hrdata    <= read_reg(rd_addr);
          hreadyout <= 1'b1;
          bus_state <= BUS_IDLE;
        end
        default:
        begin
          bus_state <= BUS_IDLE;
          hreadyout <= 1'b1;
          wr_pend   <= 1'b0;
        end
      endcase
    end
  end

  // control, constant and mask registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl0 <= `CTRL_RESET;
      ctrl1 <= `CTRL_RESET;
      tc_a0 <= `TCONST_RESET;
      tc_b0 <= `TCONST_RESET;
      tc_a1 <= `TCONST_RESET;
      tc_b1 <= `TCONST_RESET;
      mask  <= `MASK_RESET;
    end
    else if (wr_now)
    begin
      case (wr_addr)
        `REG_CTRL_CH0:  ctrl0 <= hwdata[7:0];
        `REG_CTRL_CH1:  ctrl1 <= hwdata[7:0];
        `REG_TCONST_A0: tc_a0 <= hwdata[7:0];
        `REG_TCONST_B0: tc_b0 <= hwdata[7:0];
        `REG_TCONST_A1: tc_a1 <= hwdata[7:0];
        `REG_TCONST_B1: tc_b1 <= hwdata[7:0];
        `REG_IRQ_MASK:  mask  <= hwdata[5:0];
        default:        ;  // other offsets ignored here
      endcase
    end
  end

  // free-running prescaler on the system clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      presc <= '0;
    else
      presc <= presc + `PRESC_WIDTH'(1);
  end

  // falling edge of each divided clock
  always_comb
  begin
    presc_tick[0] = div_tick(presc, `DIV_FAST);
    presc_tick[1] = div_tick(presc, `DIV_MID);
    presc_tick[2] = div_tick(presc, `DIV_SLOW);
  end

  // two-stage sync plus history for the pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
    end
    else
    begin
      pin_s1 <= {ext_rst, ext_clk};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // pin edges from synchronised levels only
  always_comb
  begin
    pin0.rise     = pin_s2[0] & ~pin_s3[0];
    pin0.fall     = ~pin_s2[0] & pin_s3[0];
    pin0.rst_rise = pin_s2[2] & ~pin_s3[2];
    pin1.rise     = pin_s2[1] & ~pin_s3[1];
    pin1.fall     = ~pin_s2[1] & pin_s3[1];
    pin1.rst_rise = pin_s2[3] & ~pin_s3[3];
  end

  // cascade pulses registered to break the loop between channels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      casc0 <= 1'b0;
      casc1 <= 1'b0;
    end
    else
    begin
      casc0 <= evt1.overflow_flag;
      casc1 <= evt0.match_a_flag;
    end
  end

  // both cascaded: no count clock at all
  assign casc_both = (ctrl0.clock_select == CLK_CASCADE)
                   & (ctrl1.clock_select == CLK_CASCADE);

  // channel 0
  timer_channel u_ch0
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ctrl        (ctrl0),
    .tc_a        (tc_a0),
    .tc_b        (tc_b0),
    .presc_tick  (presc_tick),
    .cascade_in  (casc0),
    .cascade_off (casc_both),
    .pin         (pin0),
    .cnt_wr      (wr_now & (wr_addr == `REG_COUNT_CH0)),
    .cnt_wdata   (hwdata[7:0]),
    .up_counter  (cnt0),
    .evt         (evt0)
  );

  // channel 1
  timer_channel u_ch1
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ctrl        (ctrl1),
    .tc_a        (tc_a1),
    .tc_b        (tc_b1),
    .presc_tick  (presc_tick),
    .cascade_in  (casc1),
    .cascade_off (casc_both),
    .pin         (pin1),
    .cnt_wr      (wr_now & (wr_addr == `REG_COUNT_CH1)),
    .cnt_wdata   (hwdata[7:0]),
    .up_counter  (cnt1),
    .evt         (evt1)
  );

  // status layout vectors
  always_comb
  begin
    evt_all = {evt1, evt0};
    enables = {ctrl1[7:5], ctrl0[7:5]};
    w1c     = (wr_now & (wr_addr == `REG_IRQ_STATUS)) ? hwdata[5:0] : 6'h00;
    // a new event beats a clear in the same cycle
    next_status = (status & ~w1c) | evt_all;
  end

  // sticky status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status <= `STATUS_RESET;
    else
      status <= next_status;
  end

  // interrupt: enabled, unmasked, pending
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(next_status & mask & enables);
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic quiet0;  // channel 0 free of load and clear
  assign quiet0 = ~(wr_now & (wr_addr == `REG_COUNT_CH0))
                & (ctrl0.clear_select == CLR_NONE);
  stop_holds_a: assert property (
    (ctrl0.clock_select == CLK_STOP) && quiet0 |=> $stable(cnt0))
    else $error("stopped counter moved");
  mid_div_a: assert property (
    (ctrl0.clock_select == CLK_INT_MID) && quiet0 && !presc_tick[1]
    |=> $stable(cnt0))
    else $error("counter moved off the divided tick");
  ext_rise_a: assert property (
    (ctrl0.clock_select == CLK_EXT_RISE) && quiet0 && pin0.rise
    |=> cnt0 == $past(cnt0) + 8'h01)
    else $error("rising pin edge not counted");
  ext_fall_a: assert property (
    (ctrl0.clock_select == CLK_EXT_FALL) && quiet0 && pin0.rise
    |=> $stable(cnt0))
    else $error("rising edge counted in falling mode");
  ext_both_a: assert property (
    (ctrl0.clock_select == CLK_EXT_BOTH) && quiet0 && pin0.fall
    |=> cnt0 == $past(cnt0) + 8'h01)
    else $error("falling edge missed in both mode");
  cascade_step_a: assert property (
    (ctrl0.clock_select == CLK_CASCADE) && !casc_both && quiet0
    && evt1.overflow_flag ##1 quiet0 && !casc_both
    && (ctrl0.clock_select == CLK_CASCADE)
    |=> cnt0 == $past(cnt0, 2) + 8'h01)
    else $error("cascade overflow not counted");
  cascade_off_a: assert property (
    casc_both && quiet0 |=> $stable(cnt0))
    else $error("count while both cascaded");
  irq_gate_a: assert property (
    irq |-> |(status & $past(mask) & $past(enables)))
    else $error("interrupt without enabled cause");
  clear_match_a: assert property (
    (ctrl0.clear_select == CLR_MATCH_A) && evt0.match_a_flag
    && !(wr_now && wr_addr == `REG_COUNT_CH0) |=> cnt0 == 8'h00)
    else $error("match a did not clear counter");
  ovf_flag_a: assert property (
    evt0.overflow_flag |=> status[`EVT_CH0_LSB] && cnt0 == 8'h00)
    else $error("overflow not flagged");
  match_flag_a: assert property (
    (cnt0 == tc_a0) && ($past(cnt0) != $past(tc_a0))
    |=> status[`EVT_CH0_LSB + 1])
    else $error("match a not flagged");
  match_b_flag_a: assert property (
    (cnt0 == tc_b0) && ($past(cnt0) != $past(tc_b0)) |=> status[2])
    else $error("match b not flagged");
  cov_ovf_c: cover property (evt0.overflow_flag ##1 irq);
  cov_casc_c: cover property (casc0 && ctrl0.clock_select == CLK_CASCADE);
  cov_read_c: cover property (bus_state == BUS_READ ##1 hreadyout);

endmodule : eight_bit_timer_control

`default_nettype wire

// ---- core/timer_channel.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "timer_map.svh"

module timer_channel
  import timer_pkg::*;
(
  input  wire logic        hclk,         // system clock
  input  wire logic        hresetn,      // async reset, low
  input  wire timer_ctrl_t ctrl,         // control register
  input  wire logic [7:0]  tc_a,         // time constant a
  input  wire logic [7:0]  tc_b,         // time constant b
  input  wire logic [2:0]  presc_tick,   // fast, mid, slow ticks
  input  wire logic        cascade_in,   // partner channel event
  input  wire logic        cascade_off,  // both channels cascaded
  input  wire pin_evt_t    pin,          // pin edge events
  input  wire logic        cnt_wr,       // software counter load
  input  wire logic [7:0]  cnt_wdata,    // load value
  output logic [7:0]       up_counter,   // count value
  output timer_evt_t       evt           // one-cycle events
);

  logic step;     // count this cycle
  logic clr;      // clear this cycle
  logic hit_a_q;  // counter equalled constant a last cycle
  logic hit_b_q;  // counter equalled constant b last cycle

  // select the increment source
  always_comb
  begin
    case (ctrl.clock_select)
      CLK_STOP:     step = 1'b0;
      CLK_INT_FAST: step = presc_tick[0];
      CLK_INT_MID:  step = presc_tick[1];
      CLK_INT_SLOW: step = presc_tick[2];
      CLK_CASCADE:  step = cascade_in & ~cascade_off;
      CLK_EXT_RISE: step = pin.rise;
      CLK_EXT_FALL: step = pin.fall;
      CLK_EXT_BOTH: step = pin.rise | pin.fall;
      default:      step = 1'b0;
    endcase
  end

  // compare events fire once as equality begins
  always_comb
  begin
    evt.match_a_flag  = (up_counter == tc_a) & ~hit_a_q;
    evt.match_b_flag  = (up_counter == tc_b) & ~hit_b_q;
    case (ctrl.clear_select)
      CLR_NONE:    clr = 1'b0;
      CLR_MATCH_A: clr = evt.match_a_flag;
      CLR_MATCH_B: clr = evt.match_b_flag;
      CLR_EXT:     clr = pin.rst_rise;
      default:     clr = 1'b0;
    endcase
    // wrap from the top value to zero
    evt.overflow_flag = step & ~clr & ~cnt_wr
                        & (up_counter == `COUNT_MAX);
  end

  // equality history for the compare edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hit_a_q <= 1'b0;
      hit_b_q <= 1'b0;
    end
    else
    begin
      hit_a_q <= (up_counter == tc_a);
      hit_b_q <= (up_counter == tc_b);
    end
  end

  // the counter: load beats clear beats count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      up_counter <= `COUNT_RESET;
    else if (cnt_wr)
      up_counter <= cnt_wdata;
    else if (clr)
      up_counter <= `COUNT_RESET;
    else if (step)
      up_counter <= up_counter + 8'h01;
  end

endmodule : timer_channel

`default_nettype wire

// ---- inc/timer_map.svh ----
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// register byte offsets inside the slave window
`define REG_CTRL_CH0    8'h00
`define REG_CTRL_CH1    8'h04
`define REG_COUNT_CH0   8'h08
`define REG_COUNT_CH1   8'h0C
`define REG_TCONST_A0   8'h10
`define REG_TCONST_B0   8'h14
`define REG_TCONST_A1   8'h18
`define REG_TCONST_B1   8'h1C
`define REG_IRQ_STATUS  8'h20
`define REG_IRQ_MASK    8'h24

// reset values
`define CTRL_RESET      8'h00
`define COUNT_RESET     8'h00
`define TCONST_RESET    8'hFF
`define STATUS_RESET    6'h00
`define MASK_RESET      6'h00

// field positions of the status and mask layout
`define EVT_CH0_LSB     0
`define EVT_CH1_LSB     3
`define EVT_WIDTH       3

// prescaler divisors, system clock cycles per count
`define DIV_FAST        8
`define DIV_MID         64
`define DIV_SLOW        8192
`define PRESC_WIDTH     13
`define COUNT_MAX       8'hFF

`endif

// ---- inc/timer_pkg.sv ----
package timer_pkg;

  // count source codes
  typedef enum logic [2:0]
  {
    CLK_STOP     = 3'b000,
    CLK_INT_FAST = 3'b001,
    CLK_INT_MID  = 3'b010,
    CLK_INT_SLOW = 3'b011,
    CLK_CASCADE  = 3'b100,
    CLK_EXT_RISE = 3'b101,
    CLK_EXT_FALL = 3'b110,
    CLK_EXT_BOTH = 3'b111
  } clk_sel_t;

  // counter clear codes
  typedef enum logic [1:0]
  {
    CLR_NONE    = 2'b00,
    CLR_MATCH_A = 2'b01,
    CLR_MATCH_B = 2'b10,
    CLR_EXT     = 2'b11
  } clr_sel_t;

  // control register layout, bit 7 down to bit 0
  typedef struct packed
  {
    logic     match_b_irq_enable;
    logic     match_a_irq_enable;
    logic     overflow_irq_enable;
    clr_sel_t clear_select;
    clk_sel_t clock_select;
  } timer_ctrl_t;

  // per-channel events, same order as the enables
  typedef struct packed
  {
    logic match_b_flag;
    logic match_a_flag;
    logic overflow_flag;
  } timer_evt_t;

  // synchronised pin events for one channel
  typedef struct packed
  {
    logic rise;
    logic fall;
    logic rst_rise;
  } pin_evt_t;

  // bus slave states
  typedef enum logic
  {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } bus_state_t;

endpackage : timer_pkg

// ---- test/eight_bit_timer_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "timer_map.svh"

module eight_bit_timer_control_tb
  import timer_pkg::*;
;
  logic        hclk;       // bench clock
  logic        hresetn;    // bench reset
  logic        hsel;       // bus select
  logic [31:0] haddr;      // bus address
  logic [1:0]  htrans;     // bus transfer type
  logic        hwrite;     // bus direction
  logic [2:0]  hsize;      // bus size
  logic [31:0] hwdata;     // bus write data
  wire  [31:0] hrdata;     // bus read data
  wire         hreadyout;  // slave ready, fed back
  wire         hresp;      // response
  wire  [1:0]  ext_clk;    // count pins
  wire  [1:0]  ext_rst;    // clear pins
  wire         irq;        // interrupt
  int          n_fail;          // mismatches
  int          samples_checked; // comparisons
  logic [31:0] rv;              // last read value

  eight_bit_timer_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_clk(ext_clk),
    .ext_rst(ext_rst), .irq(irq));

  pin_model pins (.hclk(hclk), .ext_clk(ext_clk), .ext_rst(ext_rst));

  // clock, 100 ns period
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  // compare and count
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // verdict and end of run
  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // single word write, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wr

  // single word read, data taken at the data-phase end edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : rd

  // read and compare
  task automatic rc(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    rd(a, rv);
    check(what, rv, exp);
  endtask : rc

  // control word: enables {b,a,ovf}, clear code, clock code
  function automatic logic [31:0] ctl(input logic [2:0] en,
                                      input clr_sel_t c, input clk_sel_t k);
    return {24'h000000, en, c, k};
  endfunction : ctl

  // reset values, read-write width, unmapped place
  task automatic t_reset();
    logic [7:0]  a[11] = '{`REG_CTRL_CH0, `REG_CTRL_CH1, `REG_COUNT_CH0,
      `REG_COUNT_CH1, `REG_TCONST_A0, `REG_TCONST_B0, `REG_TCONST_A1,
      `REG_TCONST_B1, `REG_IRQ_STATUS, `REG_IRQ_MASK, 8'h28};
    logic [31:0] e[11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, 32'hFF,
      32'hFF, 32'hFF, 32'h0, 32'h0, 32'h0};
    foreach (a[i]) rc("reset value", a[i], e[i]);
    check("okay response", hresp, 32'h0);
    wr(8'h28, 32'hFFFFFFFF);
    rc("unmapped", 8'h28, 32'h0);
    wr(`REG_CTRL_CH1, 32'hFFFFFFFF);
    rc("ctrl rw", `REG_CTRL_CH1, 32'h000000FF);
    wr(`REG_CTRL_CH1, 32'h0);
  endtask : t_reset

  // internal prescaled sources, then stop
  task automatic t_internal();
    clk_sel_t    k[3] = '{CLK_INT_FAST, CLK_INT_MID, CLK_INT_SLOW};
    int          w[3] = '{80, 640, 16384};
    logic [31:0] v;
    foreach (k[i])
    begin
      wr(`REG_CTRL_CH0, ctl(3'b000, CLR_NONE, k[i]));
      wr(`REG_COUNT_CH0, 32'h0);
      repeat (w[i]) @(posedge hclk);
      rd(`REG_COUNT_CH0, rv);
      check("prescaled count", 32'(rv >= 1 && rv <= 11
        && (i == 2 || rv >= 9) && (i < 2 || rv <= 3)), 32'h1);
    end
    wr(`REG_CTRL_CH0, ctl(3'b000, CLR_NONE, CLK_STOP));
    rd(`REG_COUNT_CH0, v);
    repeat (100) @(posedge hclk);
    pins.clk_pulses(0, 2);
    rc("stopped", `REG_COUNT_CH0, v);
  endtask : t_internal

  // external pin edge modes on channel 1
  task automatic t_external();
    clk_sel_t    k[3] = '{CLK_EXT_RISE, CLK_EXT_FALL, CLK_EXT_BOTH};
    logic [31:0] e[3] = '{32'h3, 32'h3, 32'h6};
    foreach (k[i])
    begin
      wr(`REG_CTRL_CH1, ctl(3'b000, CLR_NONE, k[i]));
      wr(`REG_COUNT_CH1, 32'h0);
      pins.clk_pulses(1, 3);
      repeat (6) @(posedge hclk);
      rc("pin edges", `REG_COUNT_CH1, e[i]);
    end
  endtask : t_external

  // cascade both ways, then both cascaded
  task automatic t_cascade();
    wr(`REG_CTRL_CH1, ctl(3'b000, CLR_NONE, CLK_EXT_RISE));
    wr(`REG_CTRL_CH0, ctl(3'b000, CLR_NONE, CLK_CASCADE));
    wr(`REG_COUNT_CH0, 32'h0);
    wr(`REG_COUNT_CH1, 32'hFE);
    pins.clk_pulses(1, 2);
    repeat (6) @(posedge hclk);
    rc("ch1 wrap", `REG_COUNT_CH1, 32'h0);
    rc("ch0 on overflow", `REG_COUNT_CH0, 32'h1);
    wr(`REG_TCONST_A0, 32'h10);
    wr(`REG_CTRL_CH0, ctl(3'b000, CLR_NONE, CLK_EXT_RISE));
    wr(`REG_CTRL_CH1, ctl(3'b000, CLR_NONE, CLK_CASCADE));
    wr(`REG_COUNT_CH0, 32'h0F);
    wr(`REG_COUNT_CH1, 32'h0);
    pins.clk_pulses(0, 1);
    repeat (6) @(posedge hclk);
    rc("ch1 on match", `REG_COUNT_CH1, 32'h1);
    wr(`REG_CTRL_CH0, ctl(3'b000, CLR_NONE, CLK_CASCADE));
    wr(`REG_COUNT_CH1, 32'hFF);
    wr(`REG_COUNT_CH0, 32'h0F);
    wr(`REG_COUNT_CH0, 32'h10);
    pins.clk_pulses(0, 2);
    pins.clk_pulses(1, 2);
    rc("both cascaded ch0", `REG_COUNT_CH0, 32'h10);
    rc("both cascaded ch1", `REG_COUNT_CH1, 32'hFF);
  endtask : t_cascade

  // flags, enables, mask and level interrupt
  task automatic t_irq();
    wr(`REG_CTRL_CH1, ctl(3'b000, CLR_NONE, CLK_STOP));
    wr(`REG_TCONST_B0, 32'h20);
    wr(`REG_CTRL_CH0, ctl(3'b111, CLR_NONE, CLK_EXT_RISE));
    wr(`REG_COUNT_CH0, 32'h0F);
    wr(`REG_IRQ_STATUS, 32'h3F);
    wr(`REG_IRQ_MASK, 32'h01);
    pins.clk_pulses(0, 1);
    repeat (6) @(posedge hclk);
    rc("match a flag", `REG_IRQ_STATUS, 32'h02);
    check("irq masked", irq, 1'b0);
    wr(`REG_IRQ_MASK, 32'h02);
    repeat (2) @(posedge hclk);
    check("irq match a", irq, 1'b1);
    wr(`REG_CTRL_CH0, ctl(3'b101, CLR_NONE, CLK_EXT_RISE));
    repeat (2) @(posedge hclk);
    check("irq a disabled", irq, 1'b0);
    wr(`REG_IRQ_STATUS, 32'h3F);
    rc("status cleared", `REG_IRQ_STATUS, 32'h0);
    wr(`REG_COUNT_CH0, 32'h1F);
    pins.clk_pulses(0, 1);
    wr(`REG_COUNT_CH0, 32'hFF);
    pins.clk_pulses(0, 1);
    repeat (6) @(posedge hclk);
    rc("match b and ovf", `REG_IRQ_STATUS, 32'h05);
    wr(`REG_IRQ_MASK, 32'h01);
    repeat (2) @(posedge hclk);
    check("irq overflow", irq, 1'b1);
    wr(`REG_IRQ_STATUS, 32'h3F);
    repeat (2) @(posedge hclk);
    check("irq after clear", irq, 1'b0);
  endtask : t_irq

  // counter clear codes
  task automatic t_clear();
    clr_sel_t    c[3] = '{CLR_NONE, CLR_MATCH_A, CLR_MATCH_B};
    logic [31:0] l[3] = '{32'h0F, 32'h0F, 32'h1F};
    logic [31:0] e[3] = '{32'h10, 32'h00, 32'h00};
    foreach (c[i])
    begin
      wr(`REG_CTRL_CH0, ctl(3'b000, c[i], CLK_EXT_RISE));
      wr(`REG_COUNT_CH0, l[i]);
      pins.clk_pulses(0, 1);
      repeat (6) @(posedge hclk);
      rc("clear code", `REG_COUNT_CH0, e[i]);
    end
    wr(`REG_CTRL_CH0, ctl(3'b000, CLR_EXT, CLK_STOP));
    wr(`REG_COUNT_CH0, 32'h55);
    pins.rst_pulse(0);
    rc("clear by pin", `REG_COUNT_CH0, 32'h0);
  endtask : t_clear

  // watchdog
  initial
  begin
    repeat (60000) @(posedge hclk);
    n_fail++;
    conclude();
  end

  // main sequence
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_internal();
    t_external();
    t_cascade();
    t_irq();
    t_clear();
    conclude();
  end
endmodule : eight_bit_timer_control_tb

`default_nettype wire

// ---- test/pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// far side: external count and clear pins, levels held 3 cycles
module pin_model
(
  input  wire logic       hclk,     // system clock
  output logic      [1:0] ext_clk,  // count pins, idle low
  output logic      [1:0] ext_rst   // clear pins, idle low
);
  initial ext_clk = 2'b00;
  initial ext_rst = 2'b00;

  // n full pulses on one count pin: n rises and n falls
  task automatic clk_pulses(input int ch, input int n);
    repeat (n)
    begin
      ext_clk[ch] <= 1'b1;
      repeat (3) @(posedge hclk);
      ext_clk[ch] <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask : clk_pulses

  // one pulse on a clear pin
  task automatic rst_pulse(input int ch);
    ext_rst[ch] <= 1'b1;
    repeat (3) @(posedge hclk);
    ext_rst[ch] <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : rst_pulse
endmodule : pin_model

`default_nettype wire
